// file: core/sdpr_params.svh
// offsets, field positions, reset values and record codes of the dual-port ram block
// assumes: included by its bare name from files that also import sdpr_pkg
`ifndef SDPR_PARAMS_SVH
`define SDPR_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SDPR_OFF_CTRL 32'h0000_0000
`define SDPR_OFF_STATUS 32'h0000_0004
`define SDPR_OFF_COLL 32'h0000_0008
`define SDPR_OFF_LOAD 32'h0000_000c

// ****************************************
// fields and reset values
// ****************************************
`define SDPR_CTRL_EN_BIT 0
`define SDPR_CTRL_LOAD_BIT 1
`define SDPR_CTRL_EN_RST 1'b1
`define SDPR_CTRL_LOAD_RST 1'b0
`define SDPR_ST_BUSY_BIT 0
`define SDPR_ST_DONE_BIT 1
`define SDPR_ST_ERR_BIT 2
`define SDPR_COLL_W 16

// ****************************************
// image record types
// ****************************************
`define SDPR_REC_DATA 8'h00
`define SDPR_REC_EOF 8'h01
`define SDPR_REC_ELA 8'h04

`endif

// file: core/sdpr_pkg.sv
// types shared by the dual-port ram block files
// assumes: compiled before every other design file
package sdpr_pkg;

  typedef enum logic [1:0] {SDPR_FMT_INFERRED, SDPR_FMT_SIGNED_INT, SDPR_FMT_UNSIGNED_INT,
                            SDPR_FMT_SIGNED_FRAC} sdpr_fmt_e;

  typedef enum logic {SDPR_INIT_BLANK, SDPR_INIT_ARRAY} sdpr_init_e;

  typedef enum logic [2:0] {SDPR_LD_LEN, SDPR_LD_AHI, SDPR_LD_ALO, SDPR_LD_TYPE, SDPR_LD_DATA,
                            SDPR_LD_CSUM, SDPR_LD_DONE} sdpr_ld_state_e;

  // one word write into the array; data sits in the low bits
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
  } sdpr_wr_s;

endpackage

// file: core/sdpr_mem.sv
// storage array with one write port and one registered read port
// assumes: single clock; en gates both the write and the read register
`timescale 1ns/10ps
module sdpr_mem
  import sdpr_pkg::*;
#(
  parameter int W = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter bit USE_INIT = 1'b0,
  parameter int INIT_LEN = 1,
  parameter logic [DEPTH*W-1:0] INIT_IMAGE = '0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire sdpr_wr_s wr,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  // blank contents are zero; an array fills from address zero up
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
      mem[i] = (USE_INIT && (i < INIT_LEN)) ? INIT_IMAGE[i*W +: W] : '0;
  end

  // writes past the depth are dropped rather than aliased
  always_ff @(posedge clk)
  begin
    if (en && wr.we && (wr.addr < DEPTH))
      mem[wr.addr[AW-1:0]] <= wr.data[W-1:0];
  end

  // non-blocking read of the old word gives read-before-write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (en)
      rdata <= mem[raddr];
  end

endmodule // sdpr_mem

// file: core/sdpr_loader.sv
// parser for binary image records that turns data bytes into word writes
// assumes: bytes arrive one per strobe, record layout len, addr hi, addr lo, type, data, checksum
`timescale 1ns/10ps
`include "sdpr_params.svh"
module sdpr_loader
  import sdpr_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic byte_vld,
  input wire logic [7:0] byte_in,
  output sdpr_wr_s wr,
  output logic busy,
  output logic done,
  output logic err
);

  localparam int BPW = (W + 7) / 8;

  sdpr_ld_state_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d, type_q, type_d, sum_q, sum_d;
  logic [15:0] off_q, off_d, upper_q, upper_d, widx_q, widx_d;
  logic [31:0] acc_q, acc_d, shifted;
  logic [2:0] nb_q, nb_d;
  logic done_q, done_d, err_q, err_d;
  sdpr_wr_s wr_q, wr_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    type_d = type_q;
    sum_d = sum_q;
    off_d = off_q;
    upper_d = upper_q;
    widx_d = widx_q;
    acc_d = acc_q;
    nb_d = nb_q;
    done_d = done_q;
    err_d = err_q;
    wr_d = '0;
    shifted = {acc_q[23:0], byte_in};
    if (start)
    begin
      st_d = SDPR_LD_LEN;
      upper_d = '0;
      done_d = 1'b0;
      err_d = 1'b0;
    end
    else if (byte_vld)
    begin
      sum_d = sum_q + byte_in;
      case (st_q)
        SDPR_LD_LEN:
        begin
          cnt_d = byte_in;
          sum_d = byte_in;
          widx_d = '0;
          nb_d = '0;
          acc_d = '0;
          st_d = SDPR_LD_AHI;
        end
        SDPR_LD_AHI:
        begin
          off_d[15:8] = byte_in;
          st_d = SDPR_LD_ALO;
        end
        SDPR_LD_ALO:
        begin
          off_d[7:0] = byte_in;
          st_d = SDPR_LD_TYPE;
        end
        SDPR_LD_TYPE:
        begin
          type_d = byte_in;
          st_d = (cnt_q == 8'h00) ? SDPR_LD_CSUM : SDPR_LD_DATA;
        end
        SDPR_LD_DATA:
        begin
          cnt_d = cnt_q - 8'h01;
          acc_d = shifted;
          nb_d = nb_q + 3'h1;
          // bytes above the word width are pad bits and are dropped
          if ((type_q == `SDPR_REC_DATA) && (nb_d == 3'(BPW)))
          begin
            wr_d.we = 1'b1;
            wr_d.addr = {upper_q, off_q} + 32'(widx_q);
            wr_d.data[W-1:0] = shifted[W-1:0];
            widx_d = widx_q + 16'h0001;
            nb_d = '0;
            acc_d = '0;
          end
          if (cnt_q == 8'h01)
            st_d = SDPR_LD_CSUM;
        end
        SDPR_LD_CSUM:
        begin
          // a trailing part word is an error; words already written stay written
          if ((sum_d != 8'h00) || ((type_q == `SDPR_REC_DATA) && (nb_q != 3'h0)))
            err_d = 1'b1;
          if (type_q == `SDPR_REC_ELA)
            upper_d = acc_q[15:0];
          if (type_q == `SDPR_REC_EOF)
          begin
            st_d = SDPR_LD_DONE;
            done_d = 1'b1;
          end
          else
            st_d = SDPR_LD_LEN;
        end
        default: st_d = st_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= SDPR_LD_LEN;
      cnt_q <= '0;
      type_q <= '0;
      sum_q <= '0;
      off_q <= '0;
      upper_q <= '0;
      widx_q <= '0;
      acc_q <= '0;
      nb_q <= '0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      wr_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      type_q <= type_d;
      sum_q <= sum_d;
      off_q <= off_d;
      upper_q <= upper_d;
      widx_q <= widx_d;
      acc_q <= acc_d;
      nb_q <= nb_d;
      done_q <= done_d;
      err_q <= err_d;
      wr_q <= wr_d;
    end
  end

  assign wr = wr_q;
  assign busy = (st_q != SDPR_LD_LEN) && (st_q != SDPR_LD_DONE);
  assign done = done_q;
  assign err = err_q;

endmodule // sdpr_loader

// file: core/sdpr_top.sv
// simple dual-port ram: registered inputs, staged read data, apb control and image loader
// assumes: one clock; user ports are synchronous to clk; tie ena high when unused
//
// What this block does
// - signed formats use the top bit of each word as sign
// - word width is left plus right bits; integer formats have no fraction bits
// - separate read and write ports, each with its own address, usable together
// - inputs always registered; read data output register chosen at build time
// - clock enable does not gate the output register
// - relaxed collision option drops the second read stage, data comes earlier
// - by default a read of the address being written returns the old word
// - without an image every location starts at zero
// - image data comes in whole bytes; word width should be byte multiple
// - narrow image values padded with ones may load as negative
// - loader accepts 32-bit addresses from extended linear address records
// - depth is a build parameter of at least one word
// - data format selectable: inferred, signed, unsigned or signed fractional
// - relaxed option: same-address read during write gives unpredictable data
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
`include "sdpr_params.svh"
module sdpr_top
  import sdpr_pkg::*;
#(
  parameter int L_BITS = 16,
  parameter int R_BITS = 0,
  parameter sdpr_fmt_e FMT = SDPR_FMT_INFERRED,
  parameter int DEPTH = 256,
  parameter bit OUT_REG = 1'b1,
  parameter bit RELAXED = 1'b0,
  parameter sdpr_init_e INIT_MODE = SDPR_INIT_BLANK,
  parameter int INIT_LEN = 1,
  // integer formats carry no fraction bits
  parameter int W = L_BITS + (((FMT == SDPR_FMT_SIGNED_INT) || (FMT == SDPR_FMT_UNSIGNED_INT)) ? 0 : R_BITS),
  parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  parameter logic [DEPTH*W-1:0] INIT_IMAGE = '0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] wr_addr,
  input wire logic wren,
  input wire logic ena,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] q,
  output logic q_sign
);

  localparam bit SIGNED_FMT = (FMT == SDPR_FMT_SIGNED_INT) || (FMT == SDPR_FMT_SIGNED_FRAC);

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    return a == off;
  endfunction

  // ****************************************
  // input registers
  // ****************************************
  logic ctrl_en_q, ctrl_en_d, load_q, load_d;
  logic ena_eff;
  logic [AW-1:0] waddr_q, waddr_d, raddr_q, raddr_d;
  logic [W-1:0] wdata_q, wdata_d;
  logic wren_q, wren_d;

  assign ena_eff = ena && ctrl_en_q;

  // addresses are taken as plain unsigned indices
  always_comb
  begin
    waddr_d = waddr_q;
    raddr_d = raddr_q;
    wdata_d = wdata_q;
    wren_d = wren_q;
    if (ena_eff)
    begin
      waddr_d = wr_addr;
      raddr_d = rd_addr;
      wdata_d = wr_data;
      wren_d = wren;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waddr_q <= '0;
      raddr_q <= '0;
      wdata_q <= '0;
      wren_q <= 1'b0;
    end
    else
    begin
      waddr_q <= waddr_d;
      raddr_q <= raddr_d;
      wdata_q <= wdata_d;
      wren_q <= wren_d;
    end
  end

  // ****************************************
  // loader and storage array
  // ****************************************
  sdpr_wr_s ld_wr, mem_wr;
  logic ld_start, ld_byte, ld_busy, ld_done, ld_err;
  logic [W-1:0] mem_rdata;
  logic coll;

  sdpr_loader #(.W(W)) u_loader (
    .clk(clk),
    .rst_n(rst_n),
    .start(ld_start),
    .byte_vld(ld_byte),
    .byte_in(pwdata[7:0]),
    .wr(ld_wr),
    .busy(ld_busy),
    .done(ld_done),
    .err(ld_err)
  );

  // user writes are held off while an image loads so the two never race
  always_comb
  begin
    mem_wr = '0;
    if (ld_wr.we)
      mem_wr = ld_wr;
    else if (wren_q && !load_q && ena_eff)
    begin
      mem_wr.we = 1'b1;
      mem_wr.addr = 32'(waddr_q);
      mem_wr.data[W-1:0] = wdata_q;
    end
  end

  sdpr_mem #(
    .W(W),
    .DEPTH(DEPTH),
    .AW(AW),
    .USE_INIT(INIT_MODE == SDPR_INIT_ARRAY),
    .INIT_LEN(INIT_LEN),
    .INIT_IMAGE(INIT_IMAGE)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .en(ena_eff || ld_wr.we),
    .wr(mem_wr),
    .raddr(raddr_q),
    .rdata(mem_rdata)
  );

  assign coll = ena_eff && wren_q && !load_q && (waddr_q == raddr_q);

  // ****************************************
  // read data stages
  // ****************************************
  logic [W-1:0] s2_q, s2_d, out_q, out_d, stage_out;

  // the second stage is what keeps same-address reads deterministic
  always_comb
  begin
    s2_d = s2_q;
    if (!RELAXED && ena_eff)
      s2_d = mem_rdata;
    stage_out = RELAXED ? mem_rdata : s2_q;
    out_d = stage_out;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s2_q <= '0;
      out_q <= '0;
    end
    else
    begin
      s2_q <= s2_d;
      out_q <= out_d;
    end
  end

  assign q = OUT_REG ? out_q : stage_out;
  assign q_sign = SIGNED_FMT ? q[W-1] : 1'b0;

  // ****************************************
  // apb slave
  // ****************************************
  logic setup, access;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic [`SDPR_COLL_W-1:0] coll_q, coll_d;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign ld_byte = access && pwrite && load_q && hit(paddr, `SDPR_OFF_LOAD);
  assign ld_start = load_d && !load_q;

  always_comb
  begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    ctrl_en_d = ctrl_en_q;
    load_d = load_q;
    coll_d = coll_q;
    if (setup)
    begin
      prdata_d = '0;
      pslverr_d = 1'b0;
      if (hit(paddr, `SDPR_OFF_CTRL))
      begin
        prdata_d[`SDPR_CTRL_EN_BIT] = ctrl_en_q;
        prdata_d[`SDPR_CTRL_LOAD_BIT] = load_q;
      end
      else if (hit(paddr, `SDPR_OFF_STATUS))
      begin
        prdata_d[`SDPR_ST_BUSY_BIT] = ld_busy;
        prdata_d[`SDPR_ST_DONE_BIT] = ld_done;
        prdata_d[`SDPR_ST_ERR_BIT] = ld_err;
      end
      else if (hit(paddr, `SDPR_OFF_COLL))
        prdata_d[`SDPR_COLL_W-1:0] = coll_q;
      else if (!hit(paddr, `SDPR_OFF_LOAD))
        pslverr_d = 1'b1;
    end
    if (access && pwrite && hit(paddr, `SDPR_OFF_CTRL))
    begin
      ctrl_en_d = pwdata[`SDPR_CTRL_EN_BIT];
      load_d = pwdata[`SDPR_CTRL_LOAD_BIT];
    end
    // a collision in the clearing cycle still counts
    if (access && pwrite && hit(paddr, `SDPR_OFF_COLL))
      coll_d = '0;
    if (coll)
      coll_d = coll_d + `SDPR_COLL_W'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      ctrl_en_q <= `SDPR_CTRL_EN_RST;
      load_q <= `SDPR_CTRL_LOAD_RST;
      coll_q <= '0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      ctrl_en_q <= ctrl_en_d;
      load_q <= load_d;
      coll_q <= coll_d;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_reread;
    ena_eff && !load_q && !wren_q && !ld_wr.we;
  endsequence

  sequence s_coll;
    coll && $stable(raddr_q) && !ld_wr.we;
  endsequence

  in_regs_a: assert property (ena_eff |=> (waddr_q == $past(wr_addr)) && (raddr_q == $past(rd_addr))
    && (wdata_q == $past(wr_data)) && (wren_q == $past(wren)))
    else $error("input registers missed an enabled capture");

  in_hold_a: assert property (!ena_eff |=> $stable(raddr_q) && $stable(waddr_q) && $stable(wren_q))
    else $error("input registers moved while disabled");

  out_free_a: assert property (OUT_REG && !ena |=> q == $past(stage_out))
    else $error("output register stalled by clock enable");

  stage_two_a: assert property (!RELAXED && ena_eff |=> s2_q == $past(mem_rdata))
    else $error("second read stage did not follow the array");

  relaxed_path_a: assert property (RELAXED && OUT_REG |=> q == $past(mem_rdata))
    else $error("relaxed path still holds an extra stage");

  rdw_old_a: assert property ((s_reread and (!RELAXED)) ##1 s_coll |=> $stable(mem_rdata))
    else $error("read during write returned new data");

  rdw_new_a: assert property (s_coll ##1 (s_reread and $stable(raddr_q)) |=> mem_rdata == $past(wdata_q, 2))
    else $error("written word not seen on the next read");

  coll_count_a: assert property (coll && !(access && pwrite) |=> coll_q == $past(coll_q) + `SDPR_COLL_W'(1))
    else $error("same-cycle read and write not counted");

  sign_bit_a: assert property ($rose(q_sign) |-> SIGNED_FMT && q[W-1])
    else $error("sign flag raised without a signed top bit");

  load_path_a: assert property (ld_wr.we |-> mem_wr == ld_wr)
    else $error("loader write lost at the array port");

endmodule // sdpr_top

// file: verif/sdpr_user_model.sv
// user datapath model that drives the write and read ports of the ram
// assumes: the bench hands it one request per clock, taken at the rising edge
`timescale 1ns/10ps
module sdpr_user_model
#(
  parameter int W = 16,
  parameter int AW = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_wr,
  input wire logic [AW-1:0] cmd_waddr,
  input wire logic [W-1:0] cmd_wdata,
  input wire logic [AW-1:0] cmd_raddr,
  output logic [W-1:0] wr_data,
  output logic [AW-1:0] wr_addr,
  output logic wren,
  output logic [AW-1:0] rd_addr
);
  // ****************************************
  // port drivers
  // ****************************************
  // idle write lines toggle so a stale word can never pass for a fresh one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wren <= 1'b0;
      wr_data <= '0;
      wr_addr <= '0;
      rd_addr <= '0;
    end
    else
    begin
      wren <= cmd_wr;
      wr_data <= cmd_wr ? cmd_wdata : ~wr_data;
      wr_addr <= cmd_wr ? cmd_waddr : ~wr_addr;
      rd_addr <= cmd_raddr;
    end
  end
endmodule // sdpr_user_model

// file: verif/tb_simple_dual_port_ram.sv
// self-checking bench for the dual-port ram: random traffic, apb registers, image load
// assumes: sdpr_pkg compiled first; one 100 MHz clock
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("unexpected %s: expected %h seen %h", nm, e, g); \
    end \
  end
module tb_simple_dual_port_ram
  import sdpr_pkg::*;
;
  localparam int W = 16;
  localparam int AW = 4;
  localparam int DEPTH = 16;
  // a fraction width that an integer format has to ignore
  localparam int FRAC = 4;
  // all-zero init array exactly as long as the memory, so the blank reference still holds
  localparam logic [DEPTH*W-1:0] ZERO_IMG = '0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ena = 1'b1, cmd_wr = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic pready, pslverr, wren, q_sign, chk_on = 1'b0;
  logic [AW-1:0] cmd_waddr = '0, cmd_raddr = '0, wr_addr, rd_addr, ra_q, wa_q;
  logic [W-1:0] cmd_wdata = '0, wr_data, q, q_f, s1, s2, q_exp, wd_q;
  logic [W-1:0] mem [16];
  logic we_q, en_bit, ld_bit, coll1, hit;
  int coll_n;
  int mismatches = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  sdpr_user_model #(.W(W), .AW(AW)) u_user (.clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr),
    .cmd_waddr(cmd_waddr), .cmd_wdata(cmd_wdata), .cmd_raddr(cmd_raddr), .wr_data(wr_data),
    .wr_addr(wr_addr), .wren(wren), .rd_addr(rd_addr));
  sdpr_top #(.L_BITS(W), .FMT(SDPR_FMT_SIGNED_INT), .DEPTH(DEPTH)) u_dut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr_data(wr_data), .wr_addr(wr_addr), .wren(wren), .ena(ena),
    .rd_addr(rd_addr), .q(q), .q_sign(q_sign));
  // relaxed copy without output register: data one array stage after capture
  sdpr_top #(.L_BITS(W), .R_BITS(FRAC), .FMT(SDPR_FMT_SIGNED_INT), .DEPTH(DEPTH), .OUT_REG(1'b0),
    .RELAXED(1'b1), .INIT_MODE(SDPR_INIT_ARRAY), .INIT_LEN(DEPTH),
    .INIT_IMAGE(ZERO_IMG)) u_fast (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .wr_data(wr_data), .wr_addr(wr_addr), .wren(wren), .ena(ena), .rd_addr(rd_addr),
    .q(q_f), .q_sign());

  // ****************************************
  // reference pipeline
  // ****************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 = '0;
      s2 = '0;
      q_exp = '0;
      ra_q = '0;
      we_q = 1'b0;
      en_bit = 1'b1;
      ld_bit = 1'b0;
      coll1 = 1'b0;
      coll_n = 0;
      foreach (mem[i]) mem[i] = '0;
    end
    else
    begin
      hit = 1'b0;
      q_exp = s2;
      if (ena && en_bit)
      begin
        s2 = s1;
        coll1 = we_q && (ra_q == wa_q);
        hit = coll1;
        coll_n += int'(hit);
        s1 = mem[ra_q];
        if (we_q && !ld_bit) mem[wa_q] = wd_q;
        ra_q = rd_addr;
        we_q = wren;
        wa_q = wr_addr;
        wd_q = wr_data;
      end
      if (psel && penable && pwrite && paddr == 32'h0)
      begin
        en_bit = pwdata[0];
        ld_bit = pwdata[1];
      end
      if (psel && penable && pwrite && paddr == 32'h8) coll_n = int'(hit);
    end
  end

  always @(negedge clk)
  begin
    if (chk_on)
    begin
      `CHK("q", q_exp, q)
      `CHK("q_sign", q_exp[W-1], q_sign)
      if (!coll1) `CHK("q_fast", s1, q_f)
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 20)
    begin
      mismatches++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("prdata", x, r)
    `CHK("pslverr", xe, e)
  endtask

  // one image record with its checksum; data bytes sit left aligned in d
  task automatic rec(input logic [7:0] len, input logic [15:0] a, input logic [7:0] t,
                     input logic [31:0] d);
    logic [7:0] s;
    s = len + a[15:8] + a[7:0] + t;
    wr(32'hc, {24'h0, len});
    wr(32'hc, {24'h0, a[15:8]});
    wr(32'hc, {24'h0, a[7:0]});
    wr(32'hc, {24'h0, t});
    for (int i = 0; i < len; i++)
    begin
      wr(32'hc, {24'h0, d[31-8*i -: 8]});
      s += d[31-8*i -: 8];
    end
    wr(32'hc, {24'h0, 8'(~s + 8'h01)});
  endtask

  task automatic traffic(input int n);
    logic [AW-1:0] a;
    repeat (n)
    begin
      @(posedge clk);
      a = AW'($urandom_range(15));
      cmd_wr <= 1'($urandom_range(1));
      cmd_waddr <= a;
      cmd_wdata <= W'($urandom);
      // one read in four aims at the word being written
      cmd_raddr <= ($urandom_range(3) == 0) ? a : AW'($urandom_range(15));
      ena <= ($urandom_range(9) != 0);
    end
    @(posedge clk);
    cmd_wr <= 1'b0;
    ena <= 1'b1;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'h8a7e));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk_on <= 1'b1;
    rd(32'h0, 32'h1, 1'b0);
    rd(32'h4, 32'h0, 1'b0);
    rd(32'h8, 32'h0, 1'b0);
    rd(32'hc, 32'h0, 1'b0);
    rd(32'h10, 32'h0, 1'b1);
    wr(32'h4, 32'hffff_ffff);
    rd(32'h4, 32'h0, 1'b0);
    fork
      traffic(400);
      begin
        repeat (80) @(posedge clk);
        wr(32'h0, 32'h0);
        repeat (20) @(posedge clk);
        wr(32'h0, 32'h1);
      end
    join
    repeat (6) @(posedge clk);
    rd(32'h8, 32'(coll_n), 1'b0);
    wr(32'h8, 32'h0);
    rd(32'h8, 32'h0, 1'b0);
    wr(32'h0, 32'h3);
    traffic(20);
    // park the read port away from the words the image rewrites
    cmd_raddr <= 4'h0;
    repeat (4) @(posedge clk);
    rec(8'h02, 16'h0, 8'h04, 32'h0001_0000);
    rec(8'h02, 16'h3, 8'h00, 32'h1234_0000);
    rec(8'h02, 16'h0, 8'h04, 32'h0);
    rec(8'h04, 16'h3, 8'h00, 32'habcd_8001);
    rec(8'h00, 16'h0, 8'h01, 32'h0);
    rd(32'h4, 32'h2, 1'b0);
    wr(32'h0, 32'h1);
    mem[3] = 16'habcd;
    mem[4] = 16'h8001;
    @(posedge clk);
    cmd_raddr <= 4'h3;
    @(posedge clk);
    cmd_raddr <= 4'h4;
    traffic(200);
    repeat (6) @(posedge clk);
    `CHK("int_width", W, u_fast.W)
    end_of_test();
  end
endmodule // tb_simple_dual_port_ram
